// *** hdl/otm_regs.svh ***
/*
 * Register indices, field positions, reset values and counts for the
 * over-temperature trip register slice.
 * Assumes each index is one 32-bit word on the bus: byte address = 4*index.
 */
`ifndef OTM_REGS_SVH
`define OTM_REGS_SVH

// register indices, byte address is four times the index
`define OTM_IDX_RSV_READBACK  8'hBD
`define OTM_IDX_RSV_CFG_BF    8'hBF
`define OTM_IDX_RSV_CFG_C0    8'hC0
`define OTM_IDX_MASTER_CTRL   8'hC1
`define OTM_IDX_LIMIT_ZONE1   8'hC4
`define OTM_IDX_LIMIT_ZONE3   8'hC5
`define OTM_IDX_LIMIT_ZONE2   8'hC9
`define OTM_IDX_ZONE_STATUS   8'hCA
`define OTM_IDX_ZONE_OUT_EN   8'hCB
`define OTM_IDX_ZONE_IRQ_EN   8'hCE
`define OTM_IDX_FAN1_CEILING  8'hD1
`define OTM_IDX_FAN2_CEILING  8'hD6
`define OTM_IDX_FAN3_CEILING  8'hDB

// word index field of haddr
`define OTM_ADDR_IDX_LSB      2
`define OTM_ADDR_IDX_MSB      9

// field positions
`define OTM_MASTER_EN_BIT     1
`define OTM_ZB_AMBIENT        0
`define OTM_ZB_DIODE_ONE      1
`define OTM_ZB_DIODE_TWO      2

// reset values
`define OTM_RST_MASTER_CTRL   8'h01
`define OTM_RST_LIMIT         8'h7F
`define OTM_RST_ZONE_STATUS   3'h0
`define OTM_RST_ZONE_OUT_EN   3'h0
`define OTM_RST_ZONE_IRQ_EN   3'h0
`define OTM_RST_FAN_CEILING   8'hFF
`define OTM_RST_RSV_CFG       8'h00
`define OTM_RST_RSV_READBACK  8'h00

// successive over-limit monitoring cycles before a zone counts as tripped
`define OTM_TRIP_HITS         2'h2

`endif

// *** hdl/otm_pkg.sv ***
/*
 * Types shared by the over-temperature trip register slice.
 * Assumes the constants header is included by the design files.
 */
package otm_pkg;

	typedef logic [7:0] otm_byte_t;
	typedef logic [2:0] otm_zones_t;

	// bus slave: idle/write data phase, or one wait cycle for a read
	typedef enum logic [1:0] {
		OTM_BUS_IDLE   = 2'b01,
		OTM_BUS_RDWAIT = 2'b10
	} otm_bus_e;

endpackage

// *** hdl/otm_zone_filter.sv ***
/*
 * One temperature zone: compares each monitoring-cycle reading against the
 * trip limit and reports the zone hot after successive over-limit cycles.
 * Assumes reading, limit and the cycle strobe come from logic on hclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "otm_regs.svh"

module otm_zone_filter
	import otm_pkg::*;
(
	input  wire logic      hclk,
	input  wire logic      hresetn,
	input  wire logic      clk_en,
	input  wire logic      sample,
	input  wire otm_byte_t reading,
	input  wire otm_byte_t trip_limit,
	output logic           zone_hot
);

	logic [1:0] hits_q;
	logic       over_now;

	// readings and limits are two's complement degrees
	assign over_now = $signed(reading) > $signed(trip_limit);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hits_q <= 2'h0;
		end else if (clk_en && sample) begin
			if (!over_now) begin
				hits_q <= 2'h0;
			end else if (hits_q != `OTM_TRIP_HITS) begin
				hits_q <= hits_q + 2'h1;
			end
		end
	end

	assign zone_hot = (hits_q == `OTM_TRIP_HITS);

	chk_hits_reset: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && sample && !over_now) |=> !zone_hot)
		else $error("zone stayed hot after an in-limit cycle");

	chk_no_single_hit: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(zone_hot) |-> ($past(hits_q) == 2'h1))
		else $error("zone went hot without a prior over-limit cycle");

endmodule

`default_nettype wire

// *** hdl/otm_trip_regs.sv ***
/*
 * Over-temperature trip register slice behind an AHB-Lite slave: trip
 * limits, output enables, sticky zone status, interrupt enables, fan duty
 * ceilings and the active-low trip pin.
 * Assumes readings, the monitoring-cycle strobe and the lock level come
 * from logic on hclk; supply_good_in is an asynchronous pin.
 */
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "otm_regs.svh"

// Behaviour
// - master enable bit 1 gates trip pin
// - three read/write 8-bit zone trip limits
// - lock freezes limits, output enables, fan ceilings
// - trip limit separate from interrupt high limit
// - reading above limit sets zone status
// - two successive over-limit cycles needed
// - output enable gates pin, status always recorded
// - write one clears only inactive events
// - supply-good rising edge clears status
// - status sticky until software clears
// - status bits: diode two, diode one, ambient
// - per-zone output enables, default off
// - three fan duty ceilings, reset full scale
module otm_trip_regs
	import otm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        monitor_cycle_done,
	input  wire otm_byte_t   temp_ambient,
	input  wire otm_byte_t   temp_diode_one,
	input  wire otm_byte_t   temp_diode_two,
	input  wire logic        config_lock,
	input  wire logic        supply_good_in,
	output logic             overtemp_trip_out_n,
	output logic             irq_out,
	output otm_byte_t        fan1_duty_ceiling,
	output otm_byte_t        fan2_duty_ceiling,
	output otm_byte_t        fan3_duty_ceiling
);

	otm_bus_e        bus_q;
	logic            wr_pend_q;
	otm_byte_t       idx_q;
	logic            hreadyout_q;
	logic [31:0]     hrdata_q;
	logic            accept;
	otm_byte_t       acc_idx;

	otm_byte_t       master_q;
	logic [2:0][7:0] lim_q;
	otm_zones_t      out_en_q;
	otm_zones_t      irq_en_q;
	otm_zones_t      status_q;
	logic [2:0][7:0] fan_q;
	otm_byte_t       rsv_bf_q;
	otm_byte_t       rsv_c0_q;
	logic            trip_n_q;
	logic            irq_q;

	logic            sg_meta_q;
	logic            sg_sync_q;
	logic            sg_prev_q;
	logic            sg_rise;

	otm_zones_t      zone_hot;
	otm_byte_t       zone_reading [3];
	logic            wr_cfg_ok;
	logic            wr_status;
	otm_zones_t      status_clr;
	otm_zones_t      status_d;
	otm_byte_t       rd_val;

	// bus slave
	// hsize is not checked: only whole-word single transfers are expected
	assign acc_idx = haddr[`OTM_ADDR_IDX_MSB:`OTM_ADDR_IDX_LSB];
	assign accept  = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q       <= OTM_BUS_IDLE;
			wr_pend_q   <= 1'b0;
			idx_q       <= 8'h00;
			hreadyout_q <= 1'b1;
		end else if (clk_en) begin
			unique case (bus_q)
				OTM_BUS_IDLE: begin
					wr_pend_q <= accept && hwrite;
					if (accept) begin
						idx_q <= acc_idx;
					end
					// one wait cycle lets a read see a write just before it
					if (accept && !hwrite) begin
						bus_q       <= OTM_BUS_RDWAIT;
						hreadyout_q <= 1'b0;
					end
				end
				OTM_BUS_RDWAIT: begin
					wr_pend_q   <= 1'b0;
					bus_q       <= OTM_BUS_IDLE;
					hreadyout_q <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (clk_en && bus_q == OTM_BUS_RDWAIT) begin
			hrdata_q <= {24'h00_0000, rd_val};
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata    = hrdata_q;
	assign hresp     = 1'b0;

	// write side effects are applied in the write data phase
	assign wr_cfg_ok = wr_pend_q && !config_lock;
	assign wr_status = wr_pend_q && idx_q == `OTM_IDX_ZONE_STATUS;

	always_comb begin
		rd_val = 8'h00;
		case (idx_q)
			`OTM_IDX_RSV_READBACK: rd_val = `OTM_RST_RSV_READBACK;
			`OTM_IDX_RSV_CFG_BF:   rd_val = rsv_bf_q;
			`OTM_IDX_RSV_CFG_C0:   rd_val = rsv_c0_q;
			`OTM_IDX_MASTER_CTRL:  rd_val = master_q;
			`OTM_IDX_LIMIT_ZONE1:  rd_val = lim_q[`OTM_ZB_DIODE_ONE];
			`OTM_IDX_LIMIT_ZONE2:  rd_val = lim_q[`OTM_ZB_AMBIENT];
			`OTM_IDX_LIMIT_ZONE3:  rd_val = lim_q[`OTM_ZB_DIODE_TWO];
			`OTM_IDX_ZONE_STATUS:  rd_val = {5'h00, status_q};
			`OTM_IDX_ZONE_OUT_EN:  rd_val = {5'h00, out_en_q};
			`OTM_IDX_ZONE_IRQ_EN:  rd_val = {5'h00, irq_en_q};
			`OTM_IDX_FAN1_CEILING: rd_val = fan_q[0];
			`OTM_IDX_FAN2_CEILING: rd_val = fan_q[1];
			`OTM_IDX_FAN3_CEILING: rd_val = fan_q[2];
			default:               rd_val = 8'h00;
		endcase
	end

	// configuration that is never locked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			master_q <= `OTM_RST_MASTER_CTRL;
			irq_en_q <= `OTM_RST_ZONE_IRQ_EN;
			rsv_bf_q <= `OTM_RST_RSV_CFG;
			rsv_c0_q <= `OTM_RST_RSV_CFG;
		end else if (clk_en && wr_pend_q) begin
			case (idx_q)
				`OTM_IDX_MASTER_CTRL: master_q <= hwdata[7:0];
				`OTM_IDX_ZONE_IRQ_EN: irq_en_q <= hwdata[2:0];
				// stored only; their meaning is left to software
				`OTM_IDX_RSV_CFG_BF:  rsv_bf_q <= hwdata[7:0];
				`OTM_IDX_RSV_CFG_C0:  rsv_c0_q <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// lockable configuration: trip limits, output enables, fan ceilings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lim_q    <= {3{`OTM_RST_LIMIT}};
			out_en_q <= `OTM_RST_ZONE_OUT_EN;
			fan_q    <= {3{`OTM_RST_FAN_CEILING}};
		end else if (clk_en && wr_cfg_ok) begin
			case (idx_q)
				`OTM_IDX_LIMIT_ZONE1:  lim_q[`OTM_ZB_DIODE_ONE] <= hwdata[7:0];
				`OTM_IDX_LIMIT_ZONE2:  lim_q[`OTM_ZB_AMBIENT]   <= hwdata[7:0];
				`OTM_IDX_LIMIT_ZONE3:  lim_q[`OTM_ZB_DIODE_TWO] <= hwdata[7:0];
				`OTM_IDX_ZONE_OUT_EN:  out_en_q <= hwdata[2:0];
				`OTM_IDX_FAN1_CEILING: fan_q[0] <= hwdata[7:0];
				`OTM_IDX_FAN2_CEILING: fan_q[1] <= hwdata[7:0];
				`OTM_IDX_FAN3_CEILING: fan_q[2] <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	assign fan1_duty_ceiling = fan_q[0];
	assign fan2_duty_ceiling = fan_q[1];
	assign fan3_duty_ceiling = fan_q[2];

	// zone comparison, one filter per status bit
	assign zone_reading[`OTM_ZB_AMBIENT]   = temp_ambient;
	assign zone_reading[`OTM_ZB_DIODE_ONE] = temp_diode_one;
	assign zone_reading[`OTM_ZB_DIODE_TWO] = temp_diode_two;

	for (genvar z = 0; z < 3; z++) begin : g_zone
		// compares against the trip limit only, never the interrupt limit
		otm_zone_filter u_filter (
			.hclk       (hclk),
			.hresetn    (hresetn),
			.clk_en     (clk_en),
			.sample     (monitor_cycle_done),
			.reading    (zone_reading[z]),
			.trip_limit (lim_q[z]),
			.zone_hot   (zone_hot[z])
		);
	end

	// supply-good pin synchroniser and rising edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sg_meta_q <= 1'b0;
			sg_sync_q <= 1'b0;
			sg_prev_q <= 1'b0;
		end else if (clk_en) begin
			sg_meta_q <= supply_good_in;
			sg_sync_q <= sg_meta_q;
			sg_prev_q <= sg_sync_q;
		end
	end

	assign sg_rise = sg_sync_q && !sg_prev_q;

	// sticky status; a hot zone refuses the clear, so set wins
	assign status_clr = wr_status ? hwdata[2:0] & ~zone_hot : 3'h0;

	always_comb begin
		status_d = (status_q & ~status_clr) | zone_hot;
		if (sg_rise) begin
			status_d = `OTM_RST_ZONE_STATUS;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= `OTM_RST_ZONE_STATUS;
		end else if (clk_en) begin
			status_q <= status_d;
		end
	end

	// pin and interrupt, both registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trip_n_q <= 1'b1;
			irq_q    <= 1'b0;
		end else if (clk_en) begin
			trip_n_q <= !(master_q[`OTM_MASTER_EN_BIT]
				&& |(status_q & out_en_q));
			irq_q    <= |(status_q & irq_en_q);
		end
	end

	assign overtemp_trip_out_n = trip_n_q;
	assign irq_out             = irq_q;

	// checks
	sequence s_read_req;
		clk_en && accept && !hwrite && bus_q == OTM_BUS_IDLE;
	endsequence

	sequence s_read_done;
		!hreadyout ##1 hreadyout;
	endsequence

	chk_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(s_read_req ##1 clk_en) |-> s_read_done)
		else $error("read data phase did not take one wait cycle");

	chk_master_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && !master_q[`OTM_MASTER_EN_BIT]) |=> overtemp_trip_out_n)
		else $error("trip pin asserted with master enable off");

	chk_pin_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && master_q[`OTM_MASTER_EN_BIT] && |(status_q & out_en_q))
		|=> !overtemp_trip_out_n)
		else $error("enabled tripped zone did not drive the pin low");

	chk_out_en_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && (status_q & out_en_q) == 3'h0) |=> overtemp_trip_out_n)
		else $error("trip pin asserted for a disabled zone");

	chk_lock_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && config_lock) |=> $stable({lim_q, out_en_q, fan_q}))
		else $error("locked configuration changed");

	chk_status_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && !sg_rise && zone_hot != 3'h0)
		|=> ((status_q & $past(zone_hot)) == $past(zone_hot)))
		else $error("hot zone did not set its status bit");

	chk_clear_guard: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_status && !sg_rise)
		|=> ((status_q & $past(hwdata[2:0]) & ~$past(zone_hot)) == 3'h0))
		else $error("write of one left an inactive status bit set");

	chk_status_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && !wr_status && !sg_rise)
		|=> ((status_q & $past(status_q)) == $past(status_q)))
		else $error("status bit dropped without a software clear");

	chk_supply_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && sg_rise) |=> status_q == 3'h0)
		else $error("supply-good rise did not clear status");

	// register writes land at the edge that ends the data phase
	chk_master_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_pend_q && idx_q == `OTM_IDX_MASTER_CTRL)
		|=> (master_q == $past(hwdata[7:0])))
		else $error("master control write did not land");

	chk_limit_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_cfg_ok && idx_q == `OTM_IDX_LIMIT_ZONE1)
		|=> (lim_q[`OTM_ZB_DIODE_ONE] == $past(hwdata[7:0])))
		else $error("unlocked trip limit write did not land");

	chk_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_cfg_ok && idx_q == `OTM_IDX_ZONE_OUT_EN)
		|=> (out_en_q == $past(hwdata[2:0])))
		else $error("unlocked output enable write did not land");

	chk_ceiling_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_cfg_ok && idx_q == `OTM_IDX_FAN1_CEILING)
		|=> (fan1_duty_ceiling == $past(hwdata[7:0])))
		else $error("unlocked fan ceiling write did not land");

	chk_write_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_status && !sg_rise)
		|=> ((status_q & $past(status_q) & ~$past(hwdata[2:0]))
		== ($past(status_q) & ~$past(hwdata[2:0]))))
		else $error("status bit written with zero was cleared");

	chk_hot_no_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(clk_en && wr_status && !sg_rise)
		|=> ((status_q & $past(zone_hot)) == $past(zone_hot)))
		else $error("status bit of a hot zone was cleared");

endmodule

`default_nettype wire

// *** testbench/tb_otm_trip_regs.sv ***
/*
 * Self-checking bench for the over-temperature trip register slice.
 * Assumes the design files and otm_regs.svh are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "otm_regs.svh"

module tb_otm_trip_regs
	import otm_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        clk_en;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd_q;
	logic [31:0] seed;
	logic        hreadyout;
	logic        hresp;
	logic        mon_done;
	logic        lock;
	logic        pgood;
	logic        trip_n;
	logic        irq;
	otm_byte_t   t_amb;
	otm_byte_t   t_d1;
	otm_byte_t   t_d2;
	otm_byte_t   f1;
	otm_byte_t   f2;
	otm_byte_t   f3;
	otm_byte_t   shadow [256];
	int          fails;
	int          num_checks;
	otm_byte_t   all_idx [13] = '{8'hBD, 8'hBF, 8'hC0, 8'hC1, 8'hC4, 8'hC5,
		8'hC9, 8'hCA, 8'hCB, 8'hCE, 8'hD1, 8'hD6, 8'hDB};
	otm_byte_t   rw_idx [6] = '{8'hC4, 8'hC5, 8'hC9, 8'hD1, 8'hD6, 8'hDB};
	otm_byte_t   lk_idx [7] = '{8'hC4, 8'hC5, 8'hC9, 8'hCB, 8'hD1, 8'hD6, 8'hDB};

	otm_trip_regs dut (
		.hclk                (hclk),
		.hresetn             (hresetn),
		.clk_en              (clk_en),
		.hsel                (hsel),
		.haddr               (haddr),
		.htrans              (htrans),
		.hwrite              (hwrite),
		.hsize               (hsize),
		.hwdata              (hwdata),
		.hready              (hreadyout),
		.hreadyout           (hreadyout),
		.hrdata              (hrdata),
		.hresp               (hresp),
		.monitor_cycle_done  (mon_done),
		.temp_ambient        (t_amb),
		.temp_diode_one      (t_d1),
		.temp_diode_two      (t_d2),
		.config_lock         (lock),
		.supply_good_in      (pgood),
		.overtemp_trip_out_n (trip_n),
		.irq_out             (irq),
		.fan1_duty_ceiling   (f1),
		.fan2_duty_ceiling   (f2),
		.fan3_duty_ceiling   (f3)
	);

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic otm_byte_t rst_val(input otm_byte_t idx);
		case (idx)
			8'hC1: return 8'h01;
			8'hC4, 8'hC5, 8'hC9: return 8'h7F;
			8'hD1, 8'hD6, 8'hDB: return 8'hFF;
			default: return 8'h00;
		endcase
	endfunction

	// status layout: diode two, diode one, ambient
	function automatic otm_byte_t zst(input logic a, input logic d1,
		input logic d2);
		return {5'h0, d2, d1, a};
	endfunction

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// sampled on the falling edge so the rising edge never races it
	task automatic wait_rdy();
		int n;
		n = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				complete_run();
			end
			@(negedge hclk);
		end
		rd_q = hrdata;
		@(posedge hclk);
	endtask

	task automatic xfer(input logic wr, input otm_byte_t idx,
		input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {22'h0, idx, 2'h0};
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	task automatic rchk(input string nm, input otm_byte_t idx,
		input otm_byte_t exp);
		xfer(1'b0, idx, 32'h0);
		chk(nm, rd_q, {24'h0, exp});
	endtask

	task automatic pulse(input otm_byte_t d1);
		t_d1     <= d1;
		mon_done <= 1'b1;
		@(posedge hclk);
		mon_done <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask

	initial begin
		hresetn = 1'b0;
		clk_en = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		mon_done = 1'b0;
		// most negative reading never exceeds any signed limit
		t_amb = 8'h80;
		t_d1 = 8'h00;
		t_d2 = 8'h80;
		lock = 1'b0;
		pgood = 1'b1;
		seed = 32'h0000_0020;
		fails = 0;
		num_checks = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("pin reset", trip_n, 32'h1);
		chk("resp", hresp, 32'h0);
		foreach (all_idx[i]) begin
			shadow[all_idx[i]] = rst_val(all_idx[i]);
			rchk("reset", all_idx[i], rst_val(all_idx[i]));
		end
		foreach (rw_idx[i]) begin
			seed = lfsr(seed);
			shadow[rw_idx[i]] = seed[7:0];
			xfer(1'b1, rw_idx[i], seed);
			rchk("rw", rw_idx[i], seed[7:0]);
		end
		chk("fan1", {24'h0, f1}, {24'h0, shadow[8'hD1]});
		chk("fan2", {24'h0, f2}, {24'h0, shadow[8'hD6]});
		chk("fan3", {24'h0, f3}, {24'h0, shadow[8'hDB]});
		lock <= 1'b1;
		foreach (lk_idx[i]) begin
			seed = lfsr(seed);
			xfer(1'b1, lk_idx[i], seed);
			rchk("locked", lk_idx[i], shadow[lk_idx[i]]);
		end
		lock <= 1'b0;
		xfer(1'b1, 8'hC2, 32'hFF);
		rchk("unmapped", 8'hC2, 8'h00);
		xfer(1'b1, 8'hBF, 32'h0000_0000);
		rchk("reserved kept", 8'hBF, 8'h00);
		xfer(1'b1, 8'hC4, 32'h50);
		xfer(1'b1, 8'hCB, 32'h2);
		xfer(1'b1, 8'hCE, 32'h2);
		xfer(1'b1, 8'hC1, 32'h2);
		pulse(8'h51);
		pulse(8'h50);
		pulse(8'h51);
		rchk("one hit", 8'hCA, 8'h00);
		chk("pin one hit", trip_n, 32'h1);
		pulse(8'h51);
		rchk("two hits", 8'hCA, zst(0, 1, 0));
		chk("pin tripped", trip_n, 32'h0);
		chk("irq set", irq, 32'h1);
		xfer(1'b1, 8'hCA, 32'h7);
		rchk("clear hot", 8'hCA, zst(0, 1, 0));
		pulse(8'h10);
		rchk("sticky", 8'hCA, zst(0, 1, 0));
		chk("pin sticky", trip_n, 32'h0);
		xfer(1'b1, 8'hCA, 32'h0);
		rchk("write zero", 8'hCA, zst(0, 1, 0));
		xfer(1'b1, 8'hCA, 32'h2);
		repeat (3) @(posedge hclk);
		rchk("cleared", 8'hCA, 8'h00);
		chk("pin cleared", trip_n, 32'h1);
		chk("irq cleared", irq, 32'h0);
		xfer(1'b1, 8'hCB, 32'h0);
		pulse(8'h7F);
		pulse(8'h7F);
		rchk("no enable", 8'hCA, zst(0, 1, 0));
		chk("pin no enable", trip_n, 32'h1);
		chk("irq unmasked", irq, 32'h1);
		xfer(1'b1, 8'hCE, 32'h0);
		repeat (3) @(posedge hclk);
		chk("irq masked", irq, 32'h0);
		xfer(1'b1, 8'hCB, 32'h2);
		xfer(1'b1, 8'hC1, 32'h0);
		repeat (3) @(posedge hclk);
		chk("pin master off", trip_n, 32'h1);
		xfer(1'b1, 8'hC1, 32'h2);
		repeat (3) @(posedge hclk);
		chk("pin master on", trip_n, 32'h0);
		pulse(8'h10);
		pgood <= 1'b0;
		repeat (4) @(posedge hclk);
		pgood <= 1'b1;
		repeat (6) @(posedge hclk);
		rchk("supply rise", 8'hCA, 8'h00);
		chk("pin supply", trip_n, 32'h1);
		// frozen clock enable: two over-limit pulses must not count
		clk_en <= 1'b0;
		pulse(8'h7F);
		pulse(8'h7F);
		clk_en <= 1'b1;
		pulse(8'h7F);
		rchk("frozen hits", 8'hCA, 8'h00);
		pulse(8'h7F);
		rchk("live hits", 8'hCA, zst(0, 1, 0));
		chk("pin live", trip_n, 32'h0);
		// second reset in mid-run returns every register to default
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("pin rearm", trip_n, 32'h1);
		chk("fan1 rearm", {24'h0, f1}, 32'h0000_00FF);
		rchk("status rearm", 8'hCA, 8'h00);
		rchk("limit rearm", 8'hC4, 8'h7F);
		complete_run();
	end
endmodule
`default_nettype wire
